// File: design/dbsp_pkg.sv
/*
  constants, command carrier and state codes for the burst sram port.
  assumes the host link clocks are slow against clk (at least 8 clk per link period).
*/
// Summary of operation
// - one address per burst, latched on input clock rising edges only
// - write words captured on rising edges of both input clocks
// - read words launched on output clocks, else on input clocks
// - each address selects two consecutive words moved in order
// - a one-bit burst counter picks first or second word
// - narrow widths start the burst counter at zero
// - wide widths start the counter at the address lsb
// - all synchronous inputs registered by the input clock pair
// - all data outputs registered by the output clock pair, else by the input clock pair
// - writes complete internally, self-timed, with no extra host strobe
// - echo strobes drive out aligned with read words
// - only rising edges of each clock act, falling edges ignored
// - data moves at twice the clock rate
// - read and write data share one set of two-way pins
package dbsp_pkg;

  // ---------------------------------------------
  // sizes
  // ---------------------------------------------
  localparam int ADDR_W = 6;
  localparam int NARROW_MAX_W = 9;
  localparam int NIBBLE_W = 4;
  localparam int BYTE_W = 9;
  localparam int NIBBLE_DATA_W = 8;

  // ---------------------------------------------
  // link clock bit positions and fallback
  // ---------------------------------------------
  localparam int CLK_K = 0;
  localparam int CLK_KN = 1;
  localparam int CLK_C = 2;
  localparam int CLK_CN = 3;
  localparam int CLK_N = 4;
  localparam logic [1:0] C_MISS_LIMIT = 2'h2;

  typedef struct packed {
    logic op_strobe_n;
    logic rd_nwr;
    logic [ADDR_W-1:0] addr;
  } dbsp_cmd_s;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_WR0 = 5'h02,
    ST_WR1 = 5'h04,
    ST_RD0 = 5'h08,
    ST_RD1 = 5'h10
  } dbsp_state_e;

endpackage

// File: design/dbsp_sync.sv
/*
  two-flop synchroniser with rising edge detect on the synchronised level.
  assumes inputs are stable for at least two clk periods around each use.
*/
`timescale 1ns/100ps
`default_nettype none
module dbsp_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic [W-1:0] rise
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;
  logic [2:0] warm_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
      warm_q <= 3'h0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
      prev_q <= sync_q;
      warm_q <= {warm_q[1:0], 1'b1};
    end
  end

  assign q = sync_q;
  // rising edge only
  // no edge until prev_q holds a real sample: an idle-high pin gives no false rise
  assign rise = warm_q[2] ? (sync_q & ~prev_q) : '0;
endmodule // dbsp_sync
`default_nettype wire

// File: design/dbsp_port.sv
/*
  device side of a double-data-rate two-word burst static memory port.
  assumes the host drives the link clocks, command, lane selects and write data,
  each held at least two clk periods around the rising edge that takes it.
*/
`timescale 1ns/100ps
`default_nettype none
module dbsp_port #(
  parameter int WIDTH = 36,
  localparam int LANE_W = (WIDTH == dbsp_pkg::NIBBLE_DATA_W) ? dbsp_pkg::NIBBLE_W : dbsp_pkg::BYTE_W,
  localparam int LANES = WIDTH / LANE_W
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic k_clk,
  input wire logic k_clk_n,
  input wire logic c_clk,
  input wire logic c_clk_n,
  input wire dbsp_pkg::dbsp_cmd_s cmd,
  input wire logic [LANES-1:0] byte_lane_mask_n,
  input wire logic [WIDTH-1:0] dq_in,
  output logic [WIDTH-1:0] dq_out,
  output logic dq_oe_n,
  output logic [1:0] echo_strobe_pair
);
  import dbsp_pkg::*;

  localparam int IDX_W = ADDR_W + 1;
  localparam int DEPTH = 2 ** IDX_W;
  localparam int CMD_W = $bits(dbsp_cmd_s);
  localparam bit NARROW = (WIDTH <= NARROW_MAX_W);

  // ---------------------------------------------
  // input registers
  // ---------------------------------------------
  logic [CLK_N-1:0] clk_s;
  logic [CLK_N-1:0] clk_r;
  logic [CMD_W-1:0] cmd_v;
  logic [LANES+WIDTH-1:0] wdat_v;
  dbsp_cmd_s cmd_s;

  dbsp_sync #(.W(CLK_N)) u_clk_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({c_clk_n, c_clk, k_clk_n, k_clk}),
    .q(clk_s),
    .rise(clk_r)
  );

  dbsp_sync #(.W(CMD_W)) u_cmd_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d(cmd),
    .q(cmd_v),
    .rise()
  );

  dbsp_sync #(.W(LANES + WIDTH)) u_dat_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({byte_lane_mask_n, dq_in}),
    .q(wdat_v),
    .rise()
  );

  assign cmd_s = cmd_v;

  wire [LANES-1:0] mask_s = wdat_v[LANES+WIDTH-1:WIDTH];
  wire [WIDTH-1:0] dq_s = wdat_v[WIDTH-1:0];
  wire k_r = clk_r[CLK_K];
  wire kn_r = clk_r[CLK_KN];

  // ---------------------------------------------
  // output clock presence
  // ---------------------------------------------
  logic c_used_q;
  logic [1:0] miss_q;
  logic c_used_d;
  logic [1:0] miss_d;

  // absence is only seen after three input clock rising edges without an output clock edge
  always_comb begin
    c_used_d = c_used_q;
    miss_d = miss_q;
    if (clk_r[CLK_C]) begin
      c_used_d = 1'b1;
      miss_d = 2'h0;
    end else if (k_r) begin
      if (miss_q == C_MISS_LIMIT) begin
        c_used_d = 1'b0;
      end else begin
        miss_d = miss_q + 2'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      c_used_q <= 1'b0;
      miss_q <= 2'h0;
    end else begin
      c_used_q <= c_used_d;
      miss_q <= miss_d;
    end
  end

  wire launch0 = c_used_q ? clk_r[CLK_C] : k_r;
  wire launch1 = c_used_q ? clk_r[CLK_CN] : kn_r;
  wire echo0 = c_used_q ? clk_s[CLK_C] : clk_s[CLK_K];
  wire echo1 = c_used_q ? clk_s[CLK_CN] : clk_s[CLK_KN];

  // ---------------------------------------------
  // burst sequencer
  // ---------------------------------------------
  dbsp_state_e st_q;
  dbsp_state_e st_d;
  logic [ADDR_W-1:0] addr_q;
  logic rd_q;
  logic cnt_q;

  wire idle = (st_q == ST_IDLE);
  wire wr_cap = ((st_q == ST_WR0) && kn_r) || ((st_q == ST_WR1) && k_r);
  wire rd_launch = ((st_q == ST_RD0) && launch0) || ((st_q == ST_RD1) && launch1);
  wire start = k_r && !cmd_s.op_strobe_n && (idle || (st_q == ST_WR1));
  wire start_cnt = NARROW ? 1'b0 : cmd_s.addr[0];
  wire [IDX_W-1:0] idx = NARROW ? {addr_q, cnt_q} : {1'b0, addr_q[ADDR_W-1:1], cnt_q};

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: begin
        if (start) begin
          st_d = cmd_s.rd_nwr ? ST_RD0 : ST_WR0;
        end
      end
      ST_WR0: begin
        if (kn_r) begin
          st_d = ST_WR1;
        end
      end
      ST_WR1: begin
        if (start) begin
          st_d = cmd_s.rd_nwr ? ST_RD0 : ST_WR0;
        end else if (k_r) begin
          st_d = ST_IDLE;
        end
      end
      ST_RD0: begin
        if (launch0) begin
          st_d = ST_RD1;
        end
      end
      ST_RD1: begin
        if (launch1) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      addr_q <= '0;
      rd_q <= 1'b0;
    end else if (start) begin
      addr_q <= cmd_s.addr;
      rd_q <= cmd_s.rd_nwr;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_q <= 1'b0;
    end else if (start) begin
      cnt_q <= start_cnt;
    end else if (wr_cap || rd_launch) begin
      cnt_q <= ~cnt_q;
    end
  end

  // ---------------------------------------------
  // array and self-timed write
  // ---------------------------------------------
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic wr_en_q;
  logic [IDX_W-1:0] wr_idx_q;
  logic [WIDTH-1:0] wr_data_q;
  logic [LANES-1:0] wr_mask_q;
  logic [WIDTH-1:0] merged;

  for (genvar l = 0; l < LANES; l++) begin : g_lane
    assign merged[l*LANE_W +: LANE_W] = wr_mask_q[l] ? mem_q[wr_idx_q][l*LANE_W +: LANE_W]
                                                     : wr_data_q[l*LANE_W +: LANE_W];
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_en_q <= 1'b0;
      wr_idx_q <= '0;
      wr_data_q <= '0;
      wr_mask_q <= '1;
    end else begin
      wr_en_q <= wr_cap;
      wr_idx_q <= idx;
      wr_data_q <= dq_s;
      wr_mask_q <= mask_s;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_en_q) begin
      mem_q[wr_idx_q] <= merged;
    end
  end

  // ---------------------------------------------
  // output registers
  // ---------------------------------------------
  logic [WIDTH-1:0] dq_out_q;
  logic dq_oe_n_q;
  logic [1:0] echo_q;

  // one word per edge, two per period
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dq_out_q <= '0;
    end else if (rd_launch) begin
      dq_out_q <= mem_q[idx];
    end
  end

  // shared pins, drive from a read launch until the next launch0 while idle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dq_oe_n_q <= 1'b1;
    end else if (rd_launch) begin
      dq_oe_n_q <= 1'b0;
    end else if (idle && launch0) begin
      dq_oe_n_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      echo_q <= 2'h0;
    end else begin
      echo_q <= {echo1, echo0};
    end
  end

  assign dq_out = dq_out_q;
  assign dq_oe_n = dq_oe_n_q;
  assign echo_strobe_pair = echo_q;
endmodule // dbsp_port
`default_nettype wire

// File: bench/dbsp_port_assertions.sv
/*
  pin-level assertions for the burst port.
  assumes link clocks far slower than clk.
*/
`timescale 1ns/100ps
`default_nettype none
module dbsp_port_assertions #(
  parameter int WIDTH = 36,
  parameter int LANES = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic k_clk,
  input wire logic k_clk_n,
  input wire logic c_clk,
  input wire logic c_clk_n,
  input wire dbsp_pkg::dbsp_cmd_s cmd,
  input wire logic [LANES-1:0] byte_lane_mask_n,
  input wire logic [WIDTH-1:0] dq_in,
  input wire logic [WIDTH-1:0] dq_out,
  input wire logic dq_oe_n,
  input wire logic [1:0] echo_strobe_pair
);
  import dbsp_pkg::*;
  // ----------
  // helpers
  // ----------
  logic [3:0] pin_q;
  logic [7:0] rise_q;
  logic [5:0] age_q;
  logic [6:0] low_q;
  wire [3:0] pins = {c_clk_n, c_clk, k_clk_n, k_clk};
  wire k_rise = k_clk & ~pin_q[0];
  wire rd_take = k_rise & ~cmd.op_strobe_n & cmd.rd_nwr;
  wire wr_take = k_rise & ~cmd.op_strobe_n & ~cmd.rd_nwr;
  // sync delay puts output moves 3 to 6 clk after a pin rise
  wire near = |rise_q[5:2];
  always_ff @(posedge clk) begin
    pin_q <= pins;
    rise_q <= {rise_q[6:0], |(pins & ~pin_q)};
    age_q <= !rst_b ? 6'h3f : rd_take ? 6'h00 : age_q + {5'h00, age_q != 6'h3f};
    low_q <= dq_oe_n ? 7'h00 : low_q + 7'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_wr_go;
    wr_take && dq_oe_n;
  endsequence
  sequence s_quiet;
    dq_oe_n [*8];
  endsequence
  out_reset_a: assert property (disable iff (1'b0) !rst_b |=> dq_oe_n && dq_out == '0)
    else $error("outputs not cleared by reset");
  launch_edge_a: assert property ($changed(dq_out) |-> near)
    else $error("read data moved without a launch edge");
  oe_edge_a: assert property ($rose(dq_oe_n) |-> near)
    else $error("drive released off a rising edge");
  read_only_a: assert property ($changed(dq_out) |-> age_q < 6'h28)
    else $error("read data moved without a read");
  oe_cause_a: assert property ($fell(dq_oe_n) |-> age_q < 6'h28)
    else $error("drive began without a read");
  echo_word_a: assert property ($fell(dq_oe_n) |-> echo_strobe_pair == 2'h1)
    else $error("echo not aligned with first word");
  burst_span_a: assert property (low_q < 7'h50)
    else $error("drive held past one burst");
  wr_release_a: assert property (s_wr_go |-> s_quiet)
    else $error("pins driven during a write");
endmodule // dbsp_port_assertions
bind dbsp_port dbsp_port_assertions #(.WIDTH(WIDTH), .LANES(LANES)) u_chk (.clk(clk), .rst_b(rst_b),
  .k_clk(k_clk), .k_clk_n(k_clk_n), .c_clk(c_clk), .c_clk_n(c_clk_n), .cmd(cmd),
  .byte_lane_mask_n(byte_lane_mask_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
  .echo_strobe_pair(echo_strobe_pair));
`default_nettype wire

// File: bench/dbsp_host.sv
/*
  host controller model: link clocks, commands, shared data pins.
  assumes clk is the device system clock.
*/
`timescale 1ns/100ps
`default_nettype none
module dbsp_host #(
  parameter int W = 36,
  parameter int L = 4
) (
  input wire logic clk,
  output logic k_clk,
  output logic k_clk_n,
  output logic c_clk,
  output logic c_clk_n,
  output dbsp_pkg::dbsp_cmd_s cmd,
  output logic [L-1:0] byte_lane_mask_n,
  output logic [W-1:0] dq_in,
  input wire logic [W-1:0] dq_out,
  input wire logic dq_oe_n,
  input wire logic [1:0] echo_strobe_pair
);
  import dbsp_pkg::*;
  // ----------
  // pins
  // ----------
  logic c_en = 1'b0;
  logic c_src;
  logic host_oe;
  logic [W-1:0] hd;
  // one shared bus, inverted when released
  assign dq_in = !dq_oe_n ? dq_out : host_oe ? hd : ~hd;
  assign k_clk_n = ~k_clk;
  assign c_clk = c_en & c_src;
  assign c_clk_n = c_en & ~c_src;
  always @(k_clk) c_src <= #40 k_clk;
  initial begin
    k_clk = 1'b0;
    cmd = '{1'b1, 1'b0, 6'h00};
    host_oe = 1'b0;
    hd = '0;
    byte_lane_mask_n = '1;
    // odd offset keeps link edges off clk edges
    #3.3;
    forever #62.5 k_clk = ~k_clk;
  end
  task automatic step;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // command on a k rise, masks with words
  task automatic xfer(input logic op_n, input logic rd, input logic [5:0] a, input logic [W-1:0] d0, d1,
    input logic [L-1:0] m0, m1, output logic [W-1:0] q0, q1, output logic lo, hi);
    @(posedge k_clk_n);
    step;
    cmd = '{op_n, rd, a};
    hd = d0;
    byte_lane_mask_n = m0;
    host_oe = !rd;
    @(posedge k_clk);
    step;
    cmd.op_strobe_n = 1'b1;
    if (rd) begin
      repeat (4) @(posedge clk);
      // words caught on the echo strobes
      @(posedge echo_strobe_pair[0]);
      #1;
      q0 = dq_out;
      lo = dq_oe_n;
      @(posedge echo_strobe_pair[1]);
      #1;
      q1 = dq_out;
      @(posedge echo_strobe_pair[0]);
      step;
      hi = dq_oe_n;
    end else begin
      // second word on the next k rise
      @(posedge k_clk_n);
      step;
      hd = d1;
      byte_lane_mask_n = m1;
      @(posedge k_clk);
      step;
      host_oe = 1'b0;
    end
  endtask
endmodule // dbsp_host
`default_nettype wire

// File: bench/test_ddr_burst_sram_port.sv
/*
  self-checking bench for the burst port, 36-bit and 9-bit options.
  assumes the host model drives every link pin.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fails++; \
  $display("unexpected %s: expected %h seen %h", n, e, s); end end
module test_ddr_burst_sram_port;
  import dbsp_pkg::*;
  // ----------
  // harness
  // ----------
  logic clk;
  logic rst_b;
  wire k_clk, k_clk_n, c_clk, c_clk_n, dq_oe_n;
  dbsp_cmd_s cmd;
  wire [3:0] mask_n;
  wire [35:0] dq_in, dq_out;
  wire [1:0] echo;
  int fails = 0;
  int checked = 0;
  logic [35:0] q0, q1;
  logic lo, hi;
  localparam logic [35:0] DA = 36'h123456789;
  localparam logic [35:0] DB = 36'habcdef012;
  localparam logic [35:0] DC = 36'h0f0f0f0f0;
  localparam logic [35:0] DD = 36'h5a5a5a5a5;
  // narrow option harness
  wire k9, k9_n, c9, c9_n, oe9_n;
  dbsp_cmd_s cmd9;
  wire [0:0] mask9_n;
  wire [8:0] dq9_in, dq9_out;
  wire [1:0] echo9;
  logic [8:0] n0, n1;
  int k_rises = 0;
  always @(posedge k_clk) k_rises++;
  dbsp_port #(.WIDTH(36)) i_dut (.clk(clk), .rst_b(rst_b), .k_clk(k_clk), .k_clk_n(k_clk_n),
    .c_clk(c_clk), .c_clk_n(c_clk_n), .cmd(cmd), .byte_lane_mask_n(mask_n), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .echo_strobe_pair(echo));
  dbsp_host #(.W(36), .L(4)) i_host (.clk(clk), .k_clk(k_clk), .k_clk_n(k_clk_n), .c_clk(c_clk),
    .c_clk_n(c_clk_n), .cmd(cmd), .byte_lane_mask_n(mask_n), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .echo_strobe_pair(echo));
  dbsp_port #(.WIDTH(9)) i_dut_narrow (.clk(clk), .rst_b(rst_b), .k_clk(k9), .k_clk_n(k9_n), .c_clk(c9),
    .c_clk_n(c9_n), .cmd(cmd9), .byte_lane_mask_n(mask9_n), .dq_in(dq9_in), .dq_out(dq9_out),
    .dq_oe_n(oe9_n), .echo_strobe_pair(echo9));
  dbsp_host #(.W(9), .L(1)) i_host_narrow (.clk(clk), .k_clk(k9), .k_clk_n(k9_n), .c_clk(c9),
    .c_clk_n(c9_n), .cmd(cmd9), .byte_lane_mask_n(mask9_n), .dq_in(dq9_in), .dq_out(dq9_out),
    .dq_oe_n(oe9_n), .echo_strobe_pair(echo9));
  task automatic wr(input logic op_n, input logic [5:0] a, input logic [35:0] d0, input logic [3:0] m0,
    input logic [35:0] d1, input logic [3:0] m1);
    i_host.xfer(op_n, 1'b0, a, d0, d1, m0, m1, q0, q1, lo, hi);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [35:0] e0, e1);
    i_host.xfer(1'b0, 1'b1, a, '0, '0, 4'hf, 4'hf, q0, q1, lo, hi);
    `CHK("first word", e0, q0)
    `CHK("second word", e1, q1)
    `CHK("drive on", 1'b0, lo)
    `CHK("drive off", 1'b1, hi)
  endtask
  // ----------
  // scenarios
  // ----------
  task automatic t_burst_order;
    wr(1'b0, 6'h01, DA, 4'h0, DB, 4'h0);
    rd_chk(6'h00, DB, DA);
    rd_chk(6'h01, DA, DB);
  endtask
  task automatic t_lane_mask;
    wr(1'b0, 6'h00, DC, 4'he, DD, 4'h7);
    rd_chk(6'h00, {DB[35:9], DC[8:0]}, {DD[35:27], DA[26:0]});
  endtask
  task automatic t_refused;
    wr(1'b1, 6'h00, DD, 4'h0, DC, 4'h0);
    rd_chk(6'h00, {DB[35:9], DC[8:0]}, {DD[35:27], DA[26:0]});
  endtask
  task automatic t_narrow;
    i_host_narrow.xfer(1'b0, 1'b0, 6'h01, 9'h1a5, 9'h05a, 1'b0, 1'b0, n0, n1, lo, hi);
    i_host_narrow.xfer(1'b0, 1'b0, 6'h01, 9'h0ff, 9'h133, 1'b1, 1'b0, n0, n1, lo, hi);
    i_host_narrow.xfer(1'b0, 1'b1, 6'h01, 9'h000, 9'h000, 1'b1, 1'b1, n0, n1, lo, hi);
    `CHK("narrow first word", 9'h1a5, n0)
    `CHK("narrow second word", 9'h133, n1)
    `CHK("narrow drive on", 1'b0, lo)
    `CHK("narrow drive off", 1'b1, hi)
  endtask
  task automatic t_out_clock;
    int n;
    @(posedge clk);
    #1;
    i_host.c_en = 1'b1;
    // a few periods so the output pair counts as present
    repeat (3) @(posedge k_clk);
    #1;
    n = k_rises;
    rd_chk(6'h01, {DD[35:27], DA[26:0]}, {DB[35:9], DC[8:0]});
    // launched on the output pair, the burst ends before a third input rise
    `CHK("input rises in read", 2, k_rises - n)
  endtask
  task automatic complete_run;
    if (fails == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    rst_b = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    rst_b = 1'b1;
    repeat (3) @(posedge clk);
    t_burst_order();
    t_lane_mask();
    t_refused();
    t_narrow();
    t_out_clock();
    complete_run();
  end
  initial begin
    #50000;
    fails++;
    complete_run();
  end
endmodule // test_ddr_burst_sram_port
`default_nettype wire
